// ### common/refsel_host_defines.svh
// Register map, field positions, reset values and counts of the reference-select host
`ifndef REFSEL_HOST_DEFINES_SVH
`define REFSEL_HOST_DEFINES_SVH

// Word indices; byte address is four times the index
`define IDX_CTRL 6'h00
`define IDX_APPLY 6'h01
`define IDX_CRYSTAL_LOAD_TRIM 6'h02
`define IDX_STATUS 6'h03
`define IDX_PLL 6'h04
`define IDX_MULT 6'h08
`define IDX_OUT 6'h0C
`define IDX_OUTPUT_DIVIDE_TOTAL 6'h12
`define IDX_LAST 6'h17

// Field positions
`define CTRL_PRIM 0
`define CTRL_MODE 2:1
`define CTRL_SEL 3
`define CTRL_FITTED 4
`define APPLY_GO 0
`define CRYSTAL_LOAD_TRIM_TRIM 4:0
`define CRYSTAL_LOAD_TRIM_DRV 9:8
`define STAT_REFUSED 6:0
`define STAT_FAST 8
`define PLL_D 6:0
`define PLL_N 19:8
`define PLL_A 23:20
`define MULT_F 13:0
`define OUT_Q 6:0
`define OUT_PM 7
`define OUT_OEM 9:8
`define OUT_UNUSED 10
`define OUTPUT_DIVIDE_TOTAL_F 8:0

// Reset values
`define RST_TRIM 5'h00
`define RST_DRIVE 2'h3
`define RST_D 7'h00
`define RST_N 12'h000
`define RST_Q 7'h00
`define RST_OEM 2'h0

// Limits and counts
`define PLL_THREE_D_MIN 7'h03
`define Q_ALL_ONES 7'h7F
`define MON_WINDOW 10'h3FF

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### common/refsel_pkg.sv
// Types shared by the reference-select host and its register slave
package refsel_pkg;

    typedef struct packed {
        logic awready;
        logic wready;
        logic have_aw;
        logic have_w;
        logic [5:0] widx;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } slave_state_t;

    typedef struct packed {
        logic prim;
        logic sel;
        logic fitted;
        logic [1:0] mode;
        logic [4:0] trim;
        logic [1:0] drive;
        logic [3:0][6:0] d;
        logic [3:0][11:0] n;
        logic [3:0] a;
        logic [5:0][6:0] q;
        logic [5:0] pm;
        logic [5:0][1:0] disabled_output_state;
        logic [5:0] unused;
        logic l_prim;
        logic l_sel;
        logic [1:0] l_mode;
        logic [4:0] l_trim;
        logic [1:0] l_drive;
        logic [3:0][6:0] l_d;
        logic [3:0][11:0] l_n;
        logic [3:0] l_a;
        logic [5:0][6:0] l_q;
        logic [5:0] l_pm;
        logic [5:0][1:0] l_oem;
        logic [6:0] refused;
        logic commit;
        logic [1:0][2:0] sync;
        logic [1:0] stable;
        logic [1:0][9:0] cnt;
        logic [9:0] win;
        logic sec_faster;
    } host_state_t;

endpackage : refsel_pkg

// ### core/ref_switch_host.sv
// Host controller that stages, checks and drives the reference-select configuration
// Functional notes
// - Never give pll_three a reference divider below three.
// - Use automatic mode only with the crystal input as primary.
// - No switchover mode when a crystal drives the crystal input.
// - Keep the secondary reference no faster than the primary. The host refuses a faster secondary only in automatic mode.
// - With an external reference keep trim at 00h and drive at 11h.
// - Do not disable a bank divider unless the bank is never used.
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "refsel_host_defines.svh"

module ref_switch_host
    import refsel_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    // AXI4-Lite register port
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Reference clocks observed for rate comparison
    input wire logic CRYSTAL_REF_INPUT,
    input wire logic AUX_CLOCK_INPUT,
    // Device configuration
    output logic PRIMARY_SOURCE_BIT,
    output logic [1:0] SWITCHOVER_MODE_FIELD,
    output logic INPUT_SELECT_PIN,
    output logic [4:0] CRYSTAL_LOAD_TRIM,
    output logic [1:0] CRYSTAL_DRIVE_STRENGTH,
    output logic [27:0] REF_DIVIDER,
    output logic [47:0] FEEDBACK_COUNT,
    output logic [3:0] FRACTIONAL_ADD,
    output logic [41:0] OUTPUT_DIVIDE_Q,
    output logic [5:0] PRESCALE_MODE_BIT,
    output logic [11:0] DISABLED_OUTPUT_STATE,
    output logic CONFIG_COMMIT
);

    host_state_t st;
    host_state_t next_st;
    logic wr_en;
    logic [5:0] wr_idx;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;
    logic [5:0] rd_idx;
    logic [31:0] rd_data;
    logic rd_hit;
    logic [31:0] old_word;
    logic [31:0] wmask;
    logic [31:0] merged;
    logic [6:0] err;
    logic [5:0] bank_bad;
    logic apply_req;
    logic [1:0] pins;

    function automatic logic [13:0] mult(input logic [11:0] n, input logic [3:0] a,
                                         input logic frac);
        if (frac && a != 4'h0) return {1'b0, n, 1'b0} + {10'h000, a} + 14'h0001;
        if (frac) return {1'b0, n, 1'b0};
        return {2'h0, n};
    endfunction : mult

    function automatic logic [8:0] output_divide_total(input logic [6:0] q, input logic pm);
        if (q == `Q_ALL_ONES) return pm ? 9'h001 : 9'h000;
        if (!pm) return 9'h002;
        return {({1'b0, q} + 8'h02), 1'b0};
    endfunction : output_divide_total

    function automatic logic [31:0] read_word(input logic [5:0] idx);
        logic [5:0] k;
        logic [31:0] w;
        w = 32'h0000_0000;
        k = 6'h00;
        if (idx == `IDX_CTRL) begin
            w[`CTRL_PRIM] = st.prim;
            w[`CTRL_MODE] = st.mode;
            w[`CTRL_SEL] = st.sel;
            w[`CTRL_FITTED] = st.fitted;
        end else if (idx == `IDX_CRYSTAL_LOAD_TRIM) begin
            w[`CRYSTAL_LOAD_TRIM_TRIM] = st.trim;
            w[`CRYSTAL_LOAD_TRIM_DRV] = st.drive;
        end else if (idx == `IDX_STATUS) begin
            w[`STAT_REFUSED] = st.refused;
            w[`STAT_FAST] = st.sec_faster;
        end else if (idx >= `IDX_PLL && idx < `IDX_MULT) begin
            k = idx - `IDX_PLL;
            w[`PLL_D] = st.d[k[1:0]];
            w[`PLL_N] = st.n[k[1:0]];
            if (k[1:0] == 2'h0) w[`PLL_A] = st.a;
        end else if (idx >= `IDX_MULT && idx < `IDX_OUT) begin
            k = idx - `IDX_MULT;
            w[`MULT_F] = mult(st.n[k[1:0]], st.a, k[1:0] == 2'h0);
        end else if (idx >= `IDX_OUT && idx < `IDX_OUTPUT_DIVIDE_TOTAL) begin
            k = idx - `IDX_OUT;
            w[`OUT_Q] = st.q[k[2:0]];
            w[`OUT_PM] = st.pm[k[2:0]];
            w[`OUT_OEM] = st.disabled_output_state[k[2:0]];
            w[`OUT_UNUSED] = st.unused[k[2:0]];
        end else if (idx >= `IDX_OUTPUT_DIVIDE_TOTAL && idx <= `IDX_LAST) begin
            k = idx - `IDX_OUTPUT_DIVIDE_TOTAL;
            w[`OUTPUT_DIVIDE_TOTAL_F] = output_divide_total(st.q[k[2:0]], st.pm[k[2:0]]);
        end
        return w;
    endfunction : read_word

    refsel_axil_slave u_slave (
        .clk(SYS_CLK), .rst(SYS_RST),
        .awaddr(S_AXI_AWADDR), .awvalid(S_AXI_AWVALID), .awready(S_AXI_AWREADY),
        .wdata(S_AXI_WDATA), .wstrb(S_AXI_WSTRB), .wvalid(S_AXI_WVALID),
        .wready(S_AXI_WREADY), .bresp(S_AXI_BRESP), .bvalid(S_AXI_BVALID),
        .bready(S_AXI_BREADY), .araddr(S_AXI_ARADDR), .arvalid(S_AXI_ARVALID),
        .arready(S_AXI_ARREADY), .rdata(S_AXI_RDATA), .rresp(S_AXI_RRESP),
        .rvalid(S_AXI_RVALID), .rready(S_AXI_RREADY),
        .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data), .wr_strb(wr_strb),
        .wr_hit(wr_hit), .rd_idx(rd_idx), .rd_data(rd_data), .rd_hit(rd_hit)
    );

    assign rd_hit = rd_idx <= `IDX_LAST;
    // The reader looks at the whole state, so it must re-run whenever any of it moves
    always_comb rd_data = read_word(rd_idx);
    assign wr_hit = wr_idx <= `IDX_CRYSTAL_LOAD_TRIM || (wr_idx >= `IDX_PLL && wr_idx < `IDX_MULT)
                    || (wr_idx >= `IDX_OUT && wr_idx < `IDX_OUTPUT_DIVIDE_TOTAL);
    always_comb old_word = read_word(wr_idx);
    assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    assign merged = (old_word & ~wmask) | (wr_data & wmask);
    assign apply_req = wr_en && wr_idx == `IDX_APPLY && merged[`APPLY_GO];
    assign pins = {AUX_CLOCK_INPUT, CRYSTAL_REF_INPUT};

    genvar b;
    generate
        for (b = 0; b < 6; b++) begin : g_bank
            // Disabling a bank is accepted only when software marked it as never used
            assign bank_bad[b] = st.q[b] == `Q_ALL_ONES && !st.pm[b] && !st.unused[b];
        end
    endgenerate

    // Any set bit blocks the whole commit, so the device never sees a half-checked set
    assign err[0] = st.d[3] < `PLL_THREE_D_MIN;
    assign err[1] = st.a != 4'h0 && {8'h00, st.a} >= st.n[0];
    assign err[2] = st.mode[1] && st.prim;
    assign err[3] = st.fitted && (st.mode[1] || st.sel);
    assign err[4] = !st.fitted && (st.trim != `RST_TRIM || st.drive != `RST_DRIVE);
    assign err[5] = |bank_bad;
    // Rate check only sees inputs well below half the system clock
    assign err[6] = st.mode[1] && st.sec_faster;

    always_comb begin
        next_st = st;
        next_st.commit = 1'b0;
        for (int i = 0; i < 2; i++) begin
            next_st.sync[i] = {st.sync[i][1:0], pins[i]};
            if (st.sync[i][1] == st.sync[i][2]) begin
                next_st.stable[i] = st.sync[i][2];
                if (st.sync[i][2] && !st.stable[i]) next_st.cnt[i] = st.cnt[i] + 10'h001;
            end
        end
        next_st.win = st.win + 10'h001;
        if (st.win == `MON_WINDOW) begin
            next_st.win = 10'h000;
            next_st.cnt = '0;
            next_st.sec_faster = st.l_prim ? st.cnt[0] > st.cnt[1] : st.cnt[1] > st.cnt[0];
        end
        if (wr_en) begin
            if (wr_idx == `IDX_CTRL) begin
                next_st.prim = merged[`CTRL_PRIM];
                next_st.mode = merged[`CTRL_MODE];
                next_st.sel = merged[`CTRL_SEL];
                next_st.fitted = merged[`CTRL_FITTED];
            end else if (wr_idx == `IDX_CRYSTAL_LOAD_TRIM) begin
                next_st.trim = merged[`CRYSTAL_LOAD_TRIM_TRIM];
                next_st.drive = merged[`CRYSTAL_LOAD_TRIM_DRV];
            end else if (wr_idx >= `IDX_PLL && wr_idx < `IDX_MULT) begin
                next_st.d[wr_idx[1:0]] = merged[`PLL_D];
                next_st.n[wr_idx[1:0]] = merged[`PLL_N];
                if (wr_idx[1:0] == 2'h0) next_st.a = merged[`PLL_A];
            end else if (wr_idx >= `IDX_OUT && wr_idx < `IDX_OUTPUT_DIVIDE_TOTAL) begin
                next_st.q[3'(wr_idx - `IDX_OUT)] = merged[`OUT_Q];
                next_st.pm[3'(wr_idx - `IDX_OUT)] = merged[`OUT_PM];
                next_st.disabled_output_state[3'(wr_idx - `IDX_OUT)] = merged[`OUT_OEM];
                next_st.unused[3'(wr_idx - `IDX_OUT)] = merged[`OUT_UNUSED];
            end
        end
        if (apply_req) begin
            next_st.refused = err;
            if (err == 7'h00) begin
                next_st.commit = 1'b1;
                next_st.l_prim = st.prim;
                next_st.l_sel = st.sel;
                next_st.l_mode = st.mode;
                next_st.l_trim = st.trim;
                next_st.l_drive = st.drive;
                next_st.l_d = st.d;
                next_st.l_n = st.n;
                next_st.l_a = st.a;
                next_st.l_q = st.q;
                next_st.l_pm = st.pm;
                next_st.l_oem = st.disabled_output_state;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            st <= '0;
            st.drive <= `RST_DRIVE;
            st.l_drive <= `RST_DRIVE;
        end else begin
            st <= next_st;
        end
    end

    assign PRIMARY_SOURCE_BIT = st.l_prim;
    assign SWITCHOVER_MODE_FIELD = st.l_mode;
    assign INPUT_SELECT_PIN = st.l_sel;
    assign CRYSTAL_LOAD_TRIM = st.l_trim;
    assign CRYSTAL_DRIVE_STRENGTH = st.l_drive;
    assign REF_DIVIDER = st.l_d;
    assign FEEDBACK_COUNT = st.l_n;
    assign FRACTIONAL_ADD = st.l_a;
    assign OUTPUT_DIVIDE_Q = st.l_q;
    assign PRESCALE_MODE_BIT = st.l_pm;
    assign DISABLED_OUTPUT_STATE = st.l_oem;
    assign CONFIG_COMMIT = st.commit;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    sequence s_bad_apply;
        apply_req && err != 7'h00;
    endsequence

    chk_pll_three_divider : assert property (CONFIG_COMMIT |-> REF_DIVIDER[27:21] >= 7'h03)
        else $error("pll_three divider below three was committed");
    chk_auto_primary : assert property (CONFIG_COMMIT &&
        SWITCHOVER_MODE_FIELD[1] |-> !PRIMARY_SOURCE_BIT)
        else $error("automatic mode committed with auxiliary primary");
    chk_crystal_pinned : assert property (apply_req && st.fitted |=> !CONFIG_COMMIT ||
        !SWITCHOVER_MODE_FIELD[1] && !INPUT_SELECT_PIN)
        else $error("switchover left active with crystal fitted");
    chk_extref_defaults : assert property (apply_req && !st.fitted |=> !CONFIG_COMMIT ||
        CRYSTAL_LOAD_TRIM == 5'h00 && CRYSTAL_DRIVE_STRENGTH == 2'h3)
        else $error("external reference committed with non-default crystal settings");
    chk_refused_hold : assert property (s_bad_apply |=> !CONFIG_COMMIT
        && $stable(REF_DIVIDER) && $stable(OUTPUT_DIVIDE_Q) && st.refused != 7'h00)
        else $error("refused configuration reached the device");
    chk_fast_secondary : assert property (apply_req && st.mode[1] && st.sec_faster
        |=> !CONFIG_COMMIT ##0 st.refused[6])
        else $error("automatic mode committed with faster secondary");

endmodule : ref_switch_host
`default_nettype wire

// ### core/refsel_axil_slave.sv
// AXI4-Lite slave front end of the reference-select host
`timescale 1ns/1ps
`default_nettype none
`include "refsel_host_defines.svh"

module refsel_axil_slave
    import refsel_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Register side
    output logic wr_en,
    output logic [5:0] wr_idx,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_hit,
    output logic [5:0] rd_idx,
    input wire logic [31:0] rd_data,
    input wire logic rd_hit
);

    slave_state_t st;
    slave_state_t next_st;

    assign awready = st.awready;
    assign wready = st.wready;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign arready = st.arready;
    assign rvalid = st.rvalid;
    assign rdata = st.rdata;
    assign rresp = st.rresp;
    assign wr_idx = st.widx;
    assign wr_data = st.wdata;
    assign wr_strb = st.wstrb;
    assign rd_idx = araddr[7:2];
    // Address and data may arrive in either order; the write fires once both are held
    assign wr_en = st.have_aw && st.have_w && !st.bvalid;

    always_comb begin
        next_st = st;
        if (awvalid && st.awready) begin
            next_st.have_aw = 1'b1;
            next_st.widx = awaddr[7:2];
            next_st.awready = 1'b0;
        end
        if (wvalid && st.wready) begin
            next_st.have_w = 1'b1;
            next_st.wdata = wdata;
            next_st.wstrb = wstrb;
            next_st.wready = 1'b0;
        end
        if (wr_en) begin
            next_st.have_aw = 1'b0;
            next_st.have_w = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (st.bvalid && bready) begin
            next_st.bvalid = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready = 1'b1;
        end
        if (arvalid && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rdata = rd_hit ? rd_data : 32'h0000_0000;
            next_st.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (st.rvalid && rready) begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            next_st_reset : begin
                st <= '0;
                st.awready <= 1'b1;
                st.wready <= 1'b1;
                st.arready <= 1'b1;
            end
        end else begin
            st <= next_st;
        end
    end

    chk_write_answer : assert property (@(posedge clk) disable iff (rst)
        wr_en |=> bvalid && !awready && !wready)
        else $error("write response not raised after both halves held");

    chk_read_hold : assert property (@(posedge clk) disable iff (rst)
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer changed before it was taken");

endmodule : refsel_axil_slave
`default_nettype wire

// ### verif/refsel_device_model.sv
// Behavioural model of the clock generator that the host configures
`timescale 1ns/1ps
`default_nettype none

module refsel_device_model
    import refsel_pkg::*;
(
    // Source half periods in ns, zero stops a source
    input wire logic [31:0] CRYS_HALF,
    input wire logic [31:0] AUX_HALF,
    // Configuration from the host
    input wire logic PRIMARY_SOURCE_BIT,
    input wire logic [1:0] SWITCHOVER_MODE_FIELD,
    input wire logic INPUT_SELECT_PIN,
    input wire logic [4:0] CRYSTAL_LOAD_TRIM,
    input wire logic [47:0] FEEDBACK_COUNT,
    input wire logic [3:0] FRACTIONAL_ADD,
    input wire logic [41:0] OUTPUT_DIVIDE_Q,
    input wire logic [5:0] PRESCALE_MODE_BIT,
    // Reference pins and internal results
    output logic CRYSTAL_REF_INPUT = 1'b0,
    output logic AUX_CLOCK_INPUT = 1'b0,
    output logic REF_CLK,
    output logic [55:0] MULT_TOTAL,
    output logic [53:0] DIV_TOTAL
);
    real load_pf;
    int sec_edges = 0;
    logic prim_clk;
    logic sec_clk;
    logic use_sec;

    // A stopped source rests low, as an unused input must be tied
    always #((CRYS_HALF == 0) ? 10 : CRYS_HALF)
        CRYSTAL_REF_INPUT = (CRYS_HALF == 0) ? 1'b0 : ~CRYSTAL_REF_INPUT;
    always #((AUX_HALF == 0) ? 10 : AUX_HALF)
        AUX_CLOCK_INPUT = (AUX_HALF == 0) ? 1'b0 : ~AUX_CLOCK_INPUT;

    assign prim_clk = PRIMARY_SOURCE_BIT ? AUX_CLOCK_INPUT : CRYSTAL_REF_INPUT;
    assign sec_clk = PRIMARY_SOURCE_BIT ? CRYSTAL_REF_INPUT : AUX_CLOCK_INPUT;
    // Primary edges clear the count, so the secondary takes over after two of its edges with no primary edge between
    always @(posedge prim_clk) sec_edges = 0;
    always @(posedge sec_clk) if (sec_edges < 2) sec_edges = sec_edges + 1;
    assign use_sec = SWITCHOVER_MODE_FIELD[1] ? (sec_edges >= 2) : INPUT_SELECT_PIN;
    // Plain mux: switching is asynchronous, so a direct route may show short pulses
    assign REF_CLK = use_sec ? sec_clk : prim_clk;
    always_comb load_pf = 3.5 + CRYSTAL_LOAD_TRIM * 0.125;

    always_comb begin
        for (int p = 0; p < 4; p++) begin
            MULT_TOTAL[14*p+:14] = 14'(FEEDBACK_COUNT[12*p+:12]);
        end
        if (FRACTIONAL_ADD != 4'h0) MULT_TOTAL[13:0] = 14'(2 * FEEDBACK_COUNT[11:0] + FRACTIONAL_ADD + 1);
        else MULT_TOTAL[13:0] = 14'(2 * FEEDBACK_COUNT[11:0]);
        for (int b = 0; b < 6; b++) begin
            if (OUTPUT_DIVIDE_Q[7*b+:7] == 7'h7F) DIV_TOTAL[9*b+:9] = {8'h00, PRESCALE_MODE_BIT[b]};
            else if (PRESCALE_MODE_BIT[b]) DIV_TOTAL[9*b+:9] = 9'((OUTPUT_DIVIDE_Q[7*b+:7] + 2) * 2);
            else DIV_TOTAL[9*b+:9] = 9'h002;
        end
    end
endmodule : refsel_device_model
`default_nettype wire

// ### verif/test_ref_select_switchover_dividers.sv
// Self-checking bench of the reference-select host driving a device model
`timescale 1ns/1ps
`default_nettype none
`include "refsel_host_defines.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
$display("BAD %s exp %0h got %0h", nm, e, g); end end

module test_ref_select_switchover_dividers
    import refsel_pkg::*;
;
    logic SYS_CLK = 1'b0, SYS_RST = 1'b1;
    logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
    logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB = 4'hF, FRACTIONAL_ADD;
    logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
    logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, SWITCHOVER_MODE_FIELD, CRYSTAL_DRIVE_STRENGTH;
    logic CRYSTAL_REF_INPUT, AUX_CLOCK_INPUT, PRIMARY_SOURCE_BIT, INPUT_SELECT_PIN, CONFIG_COMMIT;
    logic [4:0] CRYSTAL_LOAD_TRIM;
    logic [27:0] REF_DIVIDER;
    logic [47:0] FEEDBACK_COUNT;
    logic [41:0] OUTPUT_DIVIDE_Q;
    logic [5:0] PRESCALE_MODE_BIT;
    logic [11:0] DISABLED_OUTPUT_STATE;
    logic [55:0] MULT_TOTAL;
    logic [53:0] DIV_TOTAL;
    logic [31:0] CRYS_HALF = 32'h000000C8, AUX_HALF = 32'h0000012C;
    logic [31:0] seed = 32'h00003B9B;
    logic [31:0] w [24];
    int err_total = 0, samples_checked = 0, ncommit = 0;
    int d [4], n [4], a [4], q [6], pre [6], dis [6];
    // Bad staged values: fraction not below feedback count, aux primary in auto, crystal with select, trim, dead bank
    localparam logic [7:0] TA [5] = '{8'h10, 8'h00, 8'h00, 8'h08, 8'h30};
    localparam logic [31:0] TV [5] = '{32'h00500501, 32'h00000005, 32'h00000018,
                                       32'hFFFF0001, 32'h0000007F};
    localparam logic [3:0] TS [5] = '{4'hF, 4'hF, 4'hF, 4'h1, 4'hF};
    localparam logic [6:0] TE [5] = '{7'h02, 7'h04, 7'h08, 7'h10, 7'h20};
    // Rate flag of a staged aux primary is left open, so it is masked there
    localparam logic [6:0] TM [5] = '{7'h7F, 7'h3F, 7'h7F, 7'h7F, 7'h7F};

    ref_switch_host uut (.SYS_CLK, .SYS_RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
        .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
        .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
        .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .CRYSTAL_REF_INPUT, .AUX_CLOCK_INPUT,
        .PRIMARY_SOURCE_BIT, .SWITCHOVER_MODE_FIELD, .INPUT_SELECT_PIN, .CRYSTAL_LOAD_TRIM,
        .CRYSTAL_DRIVE_STRENGTH, .REF_DIVIDER, .FEEDBACK_COUNT, .FRACTIONAL_ADD,
        .OUTPUT_DIVIDE_Q, .PRESCALE_MODE_BIT, .DISABLED_OUTPUT_STATE, .CONFIG_COMMIT);
    refsel_device_model dev (.CRYS_HALF, .AUX_HALF, .PRIMARY_SOURCE_BIT, .SWITCHOVER_MODE_FIELD,
        .INPUT_SELECT_PIN, .CRYSTAL_LOAD_TRIM, .FEEDBACK_COUNT, .FRACTIONAL_ADD,
        .OUTPUT_DIVIDE_Q, .PRESCALE_MODE_BIT, .CRYSTAL_REF_INPUT, .AUX_CLOCK_INPUT,
        .REF_CLK(), .MULT_TOTAL, .DIV_TOTAL);

    always #10 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) if (CONFIG_COMMIT === 1'b1) ncommit <= ncommit + 1;

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic axw(input logic [7:0] ad, input logic [31:0] dt, input logic [3:0] sb,
                       input logic [1:0] er);
        logic done;
        done = 1'b0;
        S_AXI_AWADDR <= ad;
        S_AXI_WDATA <= dt;
        S_AXI_WSTRB <= sb;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        while (!done) begin
            @(posedge SYS_CLK);
            if (S_AXI_AWREADY === 1'b1 && S_AXI_AWVALID) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY === 1'b1 && S_AXI_WVALID) S_AXI_WVALID <= 1'b0;
            done = (S_AXI_BVALID === 1'b1);
        end
        `CHK("bresp", er, S_AXI_BRESP)
        S_AXI_BREADY <= 1'b0;
        @(posedge SYS_CLK);
    endtask : axw

    task automatic axr(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
        S_AXI_ARADDR <= ad;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do begin
            @(posedge SYS_CLK);
            if (S_AXI_ARREADY === 1'b1 && S_AXI_ARVALID) S_AXI_ARVALID <= 1'b0;
        end while (S_AXI_RVALID !== 1'b1);
        dt = S_AXI_RDATA;
        rs = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
        @(posedge SYS_CLK);
    endtask : axr

    task automatic rchk(input logic [7:0] ad, input logic [31:0] mk, input logic [31:0] e);
        logic [31:0] dt;
        logic [1:0] rs;
        axr(ad, dt, rs);
        `CHK("rresp", `RESP_OKAY, rs)
        `CHK("rdata", e, dt & mk)
    endtask : rchk

    task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
        axw(ad, dt, 4'hF, `RESP_OKAY);
        w[ad[7:2]] = dt;
    endtask : wr

    // Live outputs move, with one commit pulse, only when nothing is refused
    task automatic apply(input logic [6:0] e, input logic [6:0] mk = 7'h7F);
        int c;
        c = ncommit;
        axw(8'h04, 32'h00000001, 4'hF, `RESP_OKAY);
        rchk(8'h0C, {25'h0, mk}, {25'h0, e});
        `CHK("commits", c + (e == 7'h00), ncommit)
    endtask : apply

    task close_out();
        $display("Comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (40000) @(posedge SYS_CLK);
        err_total++;
        close_out();
    end

    initial begin
        int k;
        logic [31:0] dt;
        logic [1:0] rs;
        w = '{default: 32'h0};
        repeat (8) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        @(posedge SYS_CLK);
        `CHK("drive", 2'h3, CRYSTAL_DRIVE_STRENGTH)
        rchk(8'h08, 32'hFFFFFFFF, 32'h00000300);
        w[2] = 32'h00000300;
        axr(8'hFC, dt, rs);
        `CHK("unmapped", {`RESP_SLVERR, 32'h0}, {rs, dt})
        axw(8'h20, 32'h0, 4'hF, `RESP_SLVERR);
        axw(8'h60, 32'h0, 4'hF, `RESP_SLVERR);
        apply(7'h01);
        for (int it = 0; it < 6; it++) begin
            for (int p = 0; p < 4; p++) begin
                d[p] = (p == 3) ? 3 + rnd() % 125 : rnd() % 128;
                n[p] = 16 + rnd() % 4080;
                a[p] = (p == 0) ? rnd() % 16 : 0;
                wr(8'(16 + 4 * p), 32'((a[p] << 20) | (n[p] << 8) | d[p]));
            end
            for (int b = 0; b < 6; b++) begin
                q[b] = (b == it) ? 127 : rnd() % 127;
                pre[b] = rnd() % 2;
                dis[b] = rnd() % 3;
                wr(8'(48 + 4 * b), 32'(((b == it) ? 1024 : 0) | (dis[b] << 8) | (pre[b] << 7) | q[b]));
            end
            wr(8'h00, 32'(((rnd() % 4) << 1) | ((rnd() % 2) << 3)));
            apply(7'h00);
            `CHK("frac", 4'(a[0]), FRACTIONAL_ADD)
            `CHK("mode", w[0][2:0], {SWITCHOVER_MODE_FIELD, PRIMARY_SOURCE_BIT})
            `CHK("sel_trim", {w[0][3], 5'h00}, {INPUT_SELECT_PIN, CRYSTAL_LOAD_TRIM})
            for (int p = 0; p < 4; p++) begin
                k = (p > 0) ? n[p] : (a[0] == 0) ? 2 * n[0] : 2 * n[0] + a[0] + 1;
                `CHK("refdiv", 7'(d[p]), REF_DIVIDER[7*p+:7])
                `CHK("fbcount", 12'(n[p]), FEEDBACK_COUNT[12*p+:12])
                `CHK("mult", 14'(k), MULT_TOTAL[14*p+:14])
                rchk(8'(32 + 4 * p), 32'h00003FFF, 32'(k));
            end
            for (int b = 0; b < 6; b++) begin
                k = (q[b] == 127) ? pre[b] : (pre[b] == 1) ? (q[b] + 2) * 2 : 2;
                `CHK("dis_state", 2'(dis[b]), DISABLED_OUTPUT_STATE[2*b+:2])
                `CHK("q", 7'(q[b]), OUTPUT_DIVIDE_Q[7*b+:7])
                `CHK("div_total", 9'(k), DIV_TOTAL[9*b+:9])
                rchk(8'(72 + 4 * b), 32'h000001FF, 32'(k));
            end
        end
        for (k = 0; k < 5; k++) begin
            axw(TA[k], TV[k], TS[k], `RESP_OKAY);
            apply(TE[k], TM[k]);
            axw(TA[k], w[TA[k][7:2]], 4'hF, `RESP_OKAY);
        end
        apply(7'h00);
        AUX_HALF <= 32'h00000064;
        repeat (2200) @(posedge SYS_CLK);
        rchk(8'h0C, 32'h00000100, 32'h00000100);
        wr(8'h00, 32'h00000004);
        apply(7'h40);
        AUX_HALF <= 32'h0000012C;
        repeat (2200) @(posedge SYS_CLK);
        apply(7'h00);
        close_out();
    end
endmodule : test_ref_select_switchover_dividers
`default_nettype wire
